// ---- common/qbio_pkg.sv ----
// Constants and carrier types for the quasi-bidirectional port block.
// Assumes a host core that reaches the port latches over a special
// function register access port with direct and bit addressing.
package qbio_pkg;

  // Register offsets in the special function space
  localparam logic [7:0] PORT_ZERO_ADDR  = 8'h80;
  localparam logic [7:0] PORT_ONE_ADDR   = 8'h90;
  localparam logic [7:0] PORT_TWO_ADDR   = 8'ha0;
  localparam logic [7:0] PORT_THREE_ADDR = 8'hb0;
  localparam logic [7:0] PORT_FOUR_ADDR  = 8'hd8;

  // Reset values and field layout
  localparam logic [7:0] LATCH_RESET     = 8'hff;
  localparam logic [7:0] PORT_FOUR_MASK  = 8'h0f;
  localparam logic [7:0] BUS_FORCE_ONES  = 8'hff;
  localparam int         NUM_PORTS       = 5;
  localparam logic [2:0] PORT_FOUR_IDX   = 3'h4;

  // Access request from the core: direct byte or bit operation
  typedef struct packed {
    logic       wrEn;
    logic       bitOp;   // Single-bit write at bitSel bit index
    logic [2:0] bitSel;
    logic       bitVal;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       rdEn;
    logic       rdLatch; // Read-modify-write read path
  } qbio_req_t;

  // External bus request from the bus interface
  typedef struct packed {
    logic       active;
    logic       adDrive; // Core drives the low data byte
    logic [7:0] lowByte;
    logic [7:0] highByte;
  } qbio_bus_t;

endpackage

// ---- verilog/qbio_ports.sv ----
// Port latches, output stage control and synchronized pin reads.
// Assumes pins are sampled on sys_clk; pull-ups and the open-drain
// wire are resolved outside from the drive-low and enable outputs.
// Assumes the core raises rdLatch for read-modify-write reads and keeps
// it low for plain reads, and that extBus.active is valid each cycle.
// Limitation: a pin read lags the pin by two enabled edges, so software
// polling a fast input must allow for that latency.
`timescale 1ns/1ns
`default_nettype none
module qbio_ports (
  // Clock, reset, enable
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                clkEn,
  // Strap sampled at reset release
  input  wire logic                externalAccessStrap,
  // Register access from the core
  input  wire qbio_pkg::qbio_req_t req,
  output logic [7:0]               rdData,
  output logic                     rdValid,
  output logic                     addrHit,
  // External bus
  input  wire qbio_pkg::qbio_bus_t extBus,
  output logic [7:0]               busDataIn,
  output logic                     busModeActive,
  // Pins: input, output level, output enable
  input  wire logic [7:0]          portZeroIn,
  input  wire logic [7:0]          portOneIn,
  input  wire logic [7:0]          portTwoIn,
  input  wire logic [7:0]          portThreeIn,
  input  wire logic [3:0]          portFourIn,
  output logic [7:0]               portZeroOut,
  output logic [7:0]               portZeroOe,
  output logic [7:0]               portOneOut,
  output logic [7:0]               portOneOe,
  output logic [7:0]               portTwoOut,
  output logic [7:0]               portTwoOe,
  output logic [7:0]               portThreeOut,
  output logic [7:0]               portThreeOe,
  output logic [3:0]               portFourOut,
  output logic [3:0]               portFourOe
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Address to port index; 7 means no port
  function automatic logic [2:0] portIdx(input logic [7:0] a);
    if (a == qbio_pkg::PORT_ZERO_ADDR) portIdx = 3'h0;
    else if (a == qbio_pkg::PORT_ONE_ADDR) portIdx = 3'h1;
    else if (a == qbio_pkg::PORT_TWO_ADDR) portIdx = 3'h2;
    else if (a == qbio_pkg::PORT_THREE_ADDR) portIdx = 3'h3;
    else if (a == qbio_pkg::PORT_FOUR_ADDR) portIdx = 3'h4;
    else portIdx = 3'h7;
  endfunction

  // New latch value for byte or single-bit write
  function automatic logic [7:0] wrValue(input logic [7:0] old,
                                         input qbio_pkg::qbio_req_t r);
    logic [7:0] v;
    v = old;
    if (r.bitOp) v[r.bitSel] = r.bitVal;
    else v = r.wrData;
    wrValue = v;
  endfunction

  // ------------------------------------------------------------
  // Strap capture and bus mode
  // ------------------------------------------------------------
  logic strapLow_r;
  logic strapDone_r;
  logic busSel;

  // Strap caught on the first enabled edge after reset release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapLow_r  <= 1'b0;
      strapDone_r <= 1'b0;
    end else if (clkEn && !strapDone_r) begin
      strapLow_r  <= !externalAccessStrap;
      strapDone_r <= 1'b1;
    end
  end

  assign busSel = strapLow_r || extBus.active;

  // ------------------------------------------------------------
  // Latches
  // ------------------------------------------------------------
  localparam int NUM_PORTS_L = qbio_pkg::NUM_PORTS;
  logic [7:0] latch_r [NUM_PORTS_L];
  wire  [2:0] wrIdx  = portIdx(req.addr);
  wire        wrHit  = req.wrEn && (wrIdx != 3'h7);
  wire  [7:0] wrVal  = wrValue(latch_r[wrIdx], req);

  // Byte and bit writes land the next edge, inside the final cycle, except port zero writes in bus mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_PORTS_L; i++) begin
        latch_r[i] <= qbio_pkg::LATCH_RESET;
      end
    end else if (clkEn) begin
      if (wrHit) begin
        latch_r[wrIdx] <= (wrIdx == qbio_pkg::PORT_FOUR_IDX)
                          ? (wrVal | ~qbio_pkg::PORT_FOUR_MASK)
                          : wrVal;
      end
      if (busSel) begin
        latch_r[0] <= qbio_pkg::BUS_FORCE_ONES;
      end
    end
  end

  // ------------------------------------------------------------
  // Input synchronizers
  // ------------------------------------------------------------
  logic [35:0] syncA_r;
  logic [35:0] syncB_r;
  wire  [35:0] pinsRaw = {portFourIn, portThreeIn, portTwoIn, portOneIn, portZeroIn};

  // First stage feeds only the second; slow edges still cost two cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= '1;
      syncB_r <= '1;
    end else if (clkEn) begin
      syncA_r <= pinsRaw;
      syncB_r <= syncA_r;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  wire [2:0] rdIdx   = portIdx(req.addr);
  wire [7:0] pinByte = (rdIdx == 3'h0) ? syncB_r[7:0]   :
                       (rdIdx == 3'h1) ? syncB_r[15:8]  :
                       (rdIdx == 3'h2) ? syncB_r[23:16] :
                       (rdIdx == 3'h3) ? syncB_r[31:24] :
                       {4'h0, syncB_r[35:32]};
  wire [7:0] latByte = (rdIdx == 3'h7) ? 8'h00 :
                       (rdIdx == qbio_pkg::PORT_FOUR_IDX)
                       ? (latch_r[4] & qbio_pkg::PORT_FOUR_MASK) : latch_r[rdIdx];
  wire [7:0] rdSel   = (rdIdx == 3'h7) ? 8'h00 : (req.rdLatch ? latByte : pinByte);

  // Registered read answer one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData  <= 8'h00;
      rdValid <= 1'b0;
      addrHit <= 1'b0;
    end else if (clkEn) begin
      rdData  <= req.rdEn ? rdSel : 8'h00;
      rdValid <= req.rdEn;
      addrHit <= req.rdEn && (rdIdx != 3'h7);
    end
  end

  // ------------------------------------------------------------
  // Output stages
  // ------------------------------------------------------------
  // Oe high means the pin is actively driven; pull-ups live outside
  wire [7:0] p0Out = busSel ? extBus.lowByte : 8'h00;
  wire [7:0] p0Oe  = busSel ? {8{extBus.adDrive}} : ~latch_r[0];
  wire [7:0] p2Out = busSel ? extBus.highByte : 8'h00;
  wire [7:0] p2Oe  = busSel ? 8'hff : ~latch_r[2];

  // All pin controls registered so outputs come straight from flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      portZeroOut   <= 8'h00;
      portZeroOe    <= 8'h00;
      portOneOut    <= 8'h00;
      portOneOe     <= 8'h00;
      portTwoOut    <= 8'h00;
      portTwoOe     <= 8'h00;
      portThreeOut  <= 8'h00;
      portThreeOe   <= 8'h00;
      portFourOut   <= 4'h0;
      portFourOe    <= 4'h0;
      busDataIn     <= 8'h00;
      busModeActive <= 1'b0;
    end else if (clkEn) begin
      portZeroOut   <= p0Out;
      portZeroOe    <= p0Oe;
      portOneOut    <= 8'h00;
      portOneOe     <= ~latch_r[1];
      portTwoOut    <= p2Out;
      portTwoOe     <= p2Oe;
      portThreeOut  <= 8'h00;
      portThreeOe   <= ~latch_r[3];
      portFourOut   <= 4'h0;
      portFourOe    <= ~latch_r[4][3:0];
      busDataIn     <= syncB_r[7:0];
      busModeActive <= busSel;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence byteWrite(logic [7:0] a);
    req.wrEn && !req.bitOp && req.addr == a && clkEn && !busSel;
  endsequence

  AST_P1_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    byteWrite(qbio_pkg::PORT_ONE_ADDR) ##1 clkEn |-> ##1 portOneOe == ~$past(req.wrData, 2))
    else $error("port one drive does not follow write");
  AST_P0_FORCED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busSel && clkEn |=> latch_r[0] == 8'hff)
    else $error("port zero latch not forced in bus mode");
  AST_P2_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busSel && clkEn && !(req.wrEn && wrIdx == 3'h2) |=> $stable(latch_r[2]))
    else $error("port two latch changed in bus mode");
  AST_P0_BUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && !busSel |=> portZeroOut == 8'h00)
    else $error("port zero driven high outside bus mode");
  AST_P2_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && busSel |=> portTwoOe == 8'hff && portTwoOut == $past(extBus.highByte))
    else $error("port two not carrying upper address");
  AST_P4_UPPER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    latch_r[4][7:4] == 4'hf)
    else $error("port four upper bits changed");
  AST_SYNC: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rst_n && clkEn ##1 clkEn ##1 clkEn |-> syncB_r == $past(pinsRaw, 2))
    else $error("synchronizer depth wrong");
  AST_RMW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && req.rdEn && req.rdLatch && req.addr == qbio_pkg::PORT_ONE_ADDR
    |=> rdData == $past(latch_r[1]))
    else $error("read-modify-write did not return latch");

  // ------------------------------------------------------------
  // Further checks on reset, reads, pin drive, freeze, the strap and the bus flag
  // ------------------------------------------------------------
  // A read request that the block must answer
  sequence readTaken;
    clkEn && req.rdEn;
  endsequence

  // A read aimed at an address that no port owns
  sequence readMissed;
    clkEn && req.rdEn && rdIdx == 3'h7;
  endsequence

  // The strap seen low on its capture edge
  sequence strapSeenLow;
    clkEn && !strapDone_r && !externalAccessStrap;
  endsequence

  // A frozen cycle, in which no state may move
  sequence frozenCycle;
    !clkEn;
  endsequence

  // No pin is pulled and no answer stands on the first edge after reset
  AST_RST_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$past(rst_n) |-> portZeroOe == 8'h00 && portOneOe == 8'h00 && portTwoOe == 8'h00
    && portThreeOe == 8'h00 && portFourOe == 4'h0 && !rdValid)
    else $error("pins driven right after reset");

  // Every taken read is answered on the next edge
  AST_RD_VALID: assert property (@(posedge sys_clk) disable iff (!rst_n)
    readTaken |=> rdValid)
    else $error("read not answered");

  // Unmapped reads return zero without a hit
  AST_RD_MISS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    readMissed |=> rdData == 8'h00 && !addrHit)
    else $error("unmapped read answered as a port");

  // Quasi-bidirectional ports one, three and four only ever pull down
  AST_PULL_DOWN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    portOneOut == 8'h00 && portThreeOut == 8'h00 && portFourOut == 4'h0)
    else $error("quasi port driven high");

  // Outside bus mode port zero is open drain, released where latch is one
  AST_P0_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && !busSel |=> portZeroOe == ~$past(latch_r[0]))
    else $error("port zero drive does not follow latch");

  // Port three pull-down follows its latch
  AST_P3_DRIVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn |=> portThreeOe == ~$past(latch_r[3]))
    else $error("port three drive does not follow latch");

  // Port four drives only its four implemented pins
  AST_P4_DRIVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn |=> portFourOe == ~$past(latch_r[4][3:0]))
    else $error("port four drive does not follow latch");

  // A low clock enable holds the port one latch, the port one drive and the read valid flag
  AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frozenCycle |=> $stable(latch_r[1]) && $stable(portOneOe) && $stable(rdValid))
    else $error("state moved while frozen");

  // A low strap at capture hands ports zero and two to the bus
  AST_STRAP_MODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    strapSeenLow |=> strapLow_r && busSel)
    else $error("strap low did not select bus mode");

  // Bus-mode indication follows the select on the next edge
  AST_BUS_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && busSel |=> busModeActive)
    else $error("bus mode flag missing");

endmodule
`default_nettype wire

// ---- test/qbio_pin_model.sv ----
// Pin model: resolves one port's wires from device drive and outside drive.
// Assumes the bench holds outside levels for several clocks at a time.
`timescale 1ns/1ns
`default_nettype none
module qbio_pin_model #(
  parameter int W      = 8,
  parameter bit PULLUP = 1'b1
) (
  // Clock
  input  wire logic         sys_clk,
  // Device side
  input  wire logic [W-1:0] pinOut,
  input  wire logic [W-1:0] pinOe,
  // Outside drivers
  input  wire logic [W-1:0] extEn,
  input  wire logic [W-1:0] extVal,
  // Resolved level
  output logic [W-1:0]      pinLvl
);
  logic [W-1:0] lastLvl = '0;
  // Wired-AND: a low driver wins; a floating pin without pull-up never keeps its old level
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pinOe[i] || extEn[i])
        pinLvl[i] = (pinOut[i] | ~pinOe[i]) & (extVal[i] | ~extEn[i]);
      else
        pinLvl[i] = PULLUP ? 1'b1 : ~lastLvl[i];
    end
  end
  // Last level, used only to upset a floating pin
  always_ff @(posedge sys_clk) lastLvl <= pinLvl;
endmodule
`default_nettype wire

// ---- test/qbio_ports_tb.sv ----
// Self-checking bench for the port block with pin models on every port.
// Assumes clkEn stays high except in the freeze test; outside levels are held well over a clock.
`timescale 1ns/1ns
`default_nettype none
module qbio_ports_tb;
  logic                sys_clk, rst_n, strap, rdValid, addrHit, busMode;
  qbio_pkg::qbio_req_t req;
  qbio_pkg::qbio_bus_t bus;
  logic [7:0]          rdData, busDataIn, e0En, e0Val, e1En, e1Val;
  logic [7:0]          p0Out, p0Oe, p1Out, p1Oe, p2Out, p2Oe, p3Out, p3Oe;
  logic [7:0]          p0Pin, p1Pin, p2Pin, p3Pin;
  logic [3:0]          p4Out, p4Oe, p4Pin, e4En, e4Val;
  logic [7:0]          e2En, e2Val, e3En, e3Val;
  logic                clkEn;
  int                  errTotal, checkCount, cyc;

  qbio_ports uut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .externalAccessStrap(strap), .req(req), .rdData(rdData), .rdValid(rdValid),
    .addrHit(addrHit), .extBus(bus), .busDataIn(busDataIn), .busModeActive(busMode),
    .portZeroIn(p0Pin), .portOneIn(p1Pin), .portTwoIn(p2Pin), .portThreeIn(p3Pin),
    .portFourIn(p4Pin), .portZeroOut(p0Out), .portZeroOe(p0Oe), .portOneOut(p1Out),
    .portOneOe(p1Oe), .portTwoOut(p2Out), .portTwoOe(p2Oe), .portThreeOut(p3Out),
    .portThreeOe(p3Oe), .portFourOut(p4Out), .portFourOe(p4Oe));
  // Port zero floats when released; the others have a weak pull-up
  qbio_pin_model #(.W(8), .PULLUP(1'b0)) m0 (.sys_clk(sys_clk), .pinOut(p0Out),
    .pinOe(p0Oe), .extEn(e0En), .extVal(e0Val), .pinLvl(p0Pin));
  qbio_pin_model m1 (.sys_clk(sys_clk), .pinOut(p1Out), .pinOe(p1Oe),
    .extEn(e1En), .extVal(e1Val), .pinLvl(p1Pin));
  qbio_pin_model m2 (.sys_clk(sys_clk), .pinOut(p2Out), .pinOe(p2Oe),
    .extEn(e2En), .extVal(e2Val), .pinLvl(p2Pin));
  qbio_pin_model m3 (.sys_clk(sys_clk), .pinOut(p3Out), .pinOe(p3Oe),
    .extEn(e3En), .extVal(e3Val), .pinLvl(p3Pin));
  qbio_pin_model #(.W(4)) m4 (.sys_clk(sys_clk), .pinOut(p4Out), .pinOe(p4Oe),
    .extEn(e4En), .extVal(e4Val), .pinLvl(p4Pin));

  // Clock and a hang guard sized well above the whole run
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errTotal++;
      endOfTest();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // One write cycle, byte or single bit
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0,
                    input logic [2:0] s = 3'h0, input logic v = 1'b0);
    @(posedge sys_clk);
    req <= '{wrEn:1'b1, bitOp:b, bitSel:s, bitVal:v, addr:a, wrData:d,
             rdEn:1'b0, rdLatch:1'b0};
    @(posedge sys_clk);
    req <= '0;
  endtask
  // One read; the answer is registered on the edge that takes it
  task automatic rd(input logic [7:0] a, input logic l, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    req <= '{wrEn:1'b0, bitOp:1'b0, bitSel:3'h0, bitVal:1'b0, addr:a, wrData:8'h00,
             rdEn:1'b1, rdLatch:l};
    @(posedge sys_clk);
    req <= '0;
    #1;
    chk({nm, "_valid"}, 8'h01, {7'h00, rdValid});
    chk(nm, e, rdData);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("oe1", 8'h00, p1Oe | p0Oe | p2Oe | p3Oe | {4'h0, p4Oe});
    rd(qbio_pkg::PORT_TWO_ADDR, 1'b1, 8'hff, "latch2");
    rd(qbio_pkg::PORT_FOUR_ADDR, 1'b1, 8'h0f, "latch4");
    e2En <= 8'hff;
    e2Val <= 8'h3c;
    e3En <= 8'h0f;
    e3Val <= 8'h05;
    e4En <= 4'h3;
    e4Val <= 4'h1;
    tick(3);
    rd(qbio_pkg::PORT_TWO_ADDR, 1'b0, 8'h3c, "pins2");
    rd(qbio_pkg::PORT_THREE_ADDR, 1'b0, 8'hf5, "pins3");
    rd(qbio_pkg::PORT_FOUR_ADDR, 1'b0, 8'h0d, "pins4");
    {e2En, e3En, e4En} <= '0;
  endtask
  // Clock enable low must hold the port three latch; then port three drives low
  task automatic t_freeze();
    clkEn <= 1'b0;
    wr(qbio_pkg::PORT_THREE_ADDR, 8'h00);
    tick(2);
    chk("oe3frz", 8'h00, p3Oe);
    clkEn <= 1'b1;
    wr(qbio_pkg::PORT_THREE_ADDR, 8'h00);
    tick(2);
    chk("oe3", 8'hff, p3Oe);
    chk("out3", 8'h00, p3Out | {4'h0, p4Out});
  endtask
  task automatic t_direction();
    wr(qbio_pkg::PORT_ONE_ADDR, 8'h0f);
    tick(2);
    chk("oe1", 8'hf0, p1Oe);
    chk("out1", 8'h00, p1Out);
    e1En <= 8'h0f;
    e1Val <= 8'h0a;
    tick(3);
    rd(qbio_pkg::PORT_ONE_ADDR, 1'b0, 8'h0a, "pins1");
    rd(qbio_pkg::PORT_ONE_ADDR, 1'b1, 8'h0f, "latch1");
    e1En <= 8'h00;
  endtask
  task automatic t_port_four_bits();
    wr(qbio_pkg::PORT_FOUR_ADDR, 8'hf5);
    tick(2);
    chk("oe4", 8'h0a, {4'h0, p4Oe});
    rd(qbio_pkg::PORT_FOUR_ADDR, 1'b1, 8'h05, "latch4");
    wr(qbio_pkg::PORT_ZERO_ADDR, 8'h00, 1'b1, 3'h3);
    tick(2);
    chk("oe0", 8'h08, p0Oe);
    rd(qbio_pkg::PORT_ZERO_ADDR, 1'b1, 8'hf7, "latch0");
    rd(8'h85, 1'b1, 8'h00, "unmapped");
    chk("hit", 8'h00, {7'h00, addrHit});
    wr(qbio_pkg::PORT_ZERO_ADDR, 8'h00, 1'b1, 3'h3, 1'b1);
    rd(qbio_pkg::PORT_ZERO_ADDR, 1'b1, 8'hff, "latch0set");
  endtask
  task automatic t_bus();
    wr(qbio_pkg::PORT_TWO_ADDR, 8'h3c);
    bus <= '{active:1'b1, adDrive:1'b1, lowByte:8'h5a, highByte:8'hc3};
    tick(3);
    chk("mode", 8'h01, {7'h00, busMode});
    chk("oe2", 8'hff, p2Oe);
    chk("out2", 8'hc3, p2Out);
    chk("oe0", 8'hff, p0Oe);
    chk("out0", 8'h5a, p0Out);
    rd(qbio_pkg::PORT_ZERO_ADDR, 1'b1, 8'hff, "latch0");
    rd(qbio_pkg::PORT_TWO_ADDR, 1'b1, 8'h3c, "latch2");
    bus.adDrive <= 1'b0;
    e0En <= 8'hff;
    e0Val <= 8'h96;
    tick(4);
    chk("oe0", 8'h00, p0Oe);
    chk("busin", 8'h96, busDataIn);
    bus <= '0;
    e0En <= 8'h00;
    tick(3);
    chk("oe2", 8'hc3, p2Oe);
    chk("oe0", 8'h00, p0Oe);
  endtask
  task automatic t_strap();
    strap <= 1'b0;
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(3);
    chk("mode", 8'h01, {7'h00, busMode});
    chk("oe2", 8'hff, p2Oe);
  endtask

  task automatic endOfTest();
    $display("checks %0d errors %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    strap = 1'b1;
    req = '0;
    bus = '0;
    {e0En, e0Val, e1En, e1Val} = '0;
    {e2En, e2Val, e3En, e3Val, e4En, e4Val} = '0;
    clkEn = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    tick(2);
    t_reset();
    t_direction();
    t_port_four_bits();
    t_bus();
    t_freeze();
    t_strap();
    endOfTest();
  end
endmodule
`default_nettype wire
